/* File: src/ssm_top.sv */
// Supply supervisor and monitor mode control with hazard check and settle flags.
// Assumes an AXI4-Lite master, synchronous mode and wake inputs, one clock.
`timescale 1ns/10ps
module ssm_top
#(
   parameter int SETTLE_NORM_CYC = ssm_pkg::SETTLE_NORM_CYC
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // AXI4-Lite write address and data
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [ssm_pkg::ADDR_W-1:0] AWADDR,
   input wire logic [2:0] AWPROT,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // AXI4-Lite write response
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // AXI4-Lite read
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [ssm_pkg::ADDR_W-1:0] ARADDR,
   input wire logic [2:0] ARPROT,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // Power mode and wake events
   input wire logic [1:0] PWR_MODE,
   input wire logic WAKE_IRQ,
   input wire logic SOFT_POWER_UP_CLEAR,
   // Unit states and status
   output logic [1:0] LOW_SUP_STATE,
   output logic [1:0] LOW_MON_STATE,
   output logic [1:0] HIGH_SUP_STATE,
   output logic [1:0] HIGH_MON_STATE,
   output logic LOW_WAKE_FAST,
   output logic HAZARD_CHECK,
   output logic LOW_SETTLE_PENDING,
   output logic HIGH_SETTLE_PENDING,
   output logic LOCKED_UP,
   output logic IRQ
);
   localparam logic [2:0] SEL_LOW = 3'h0;
   localparam logic [2:0] SEL_HIGH = 3'h1;
   localparam logic [2:0] SEL_STATUS = 3'h2;
   localparam logic [2:0] SEL_MASK = 3'h3;
   localparam logic [2:0] SEL_STATE = 3'h4;
   localparam logic [2:0] SEL_NONE = 3'h7;

   // Register index for an address; unaligned or unknown gives SEL_NONE.
   function automatic logic [2:0] reg_sel(input logic [ssm_pkg::ADDR_W-1:0] a);
      unique case (a)
         ssm_pkg::OFF_LOW_CTL: reg_sel = SEL_LOW;
         ssm_pkg::OFF_HIGH_CTL: reg_sel = SEL_HIGH;
         ssm_pkg::OFF_STATUS: reg_sel = SEL_STATUS;
         ssm_pkg::OFF_MASK: reg_sel = SEL_MASK;
         ssm_pkg::OFF_STATE: reg_sel = SEL_STATE;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction

   // Operating state of one unit; monitors have no keep bit and pass 1.
   function automatic ssm_pkg::ssm_unit_e unit_state(input logic en, input logic keep,
      input logic fp, input logic auto_c, input logic deep);
      if (!en)
         unit_state = ssm_pkg::UNIT_OFF;
      else if (!deep)
         unit_state = fp ? ssm_pkg::UNIT_FULL : ssm_pkg::UNIT_NORMAL;
      else if (auto_c)
         unit_state = (keep && fp) ? ssm_pkg::UNIT_NORMAL : ssm_pkg::UNIT_OFF;
      else if (keep)
         unit_state = fp ? ssm_pkg::UNIT_FULL : ssm_pkg::UNIT_NORMAL;
      else
         unit_state = ssm_pkg::UNIT_OFF;
   endfunction

   logic aw_have_r;
   logic w_have_r;
   logic [ssm_pkg::ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic w_lane0_r;
   logic do_write;
   logic [2:0] wsel;
   logic rd_take;
   logic [2:0] rsel;
   logic [ssm_pkg::CTL_W-1:0] low_ctl_r;
   logic [ssm_pkg::CTL_W-1:0] high_ctl_r;
   logic [ssm_pkg::ST_W-1:0] status_r;
   logic [ssm_pkg::ST_W-1:0] mask_r;
   logic [ssm_pkg::ST_W-1:0] events;
   logic low_wr;
   logic high_wr;
   logic [1:0] tmr_start;
   logic [1:0] tmr_busy;
   logic [1:0] tmr_busy_d_r;
   logic [ssm_pkg::CNT_W-1:0] tmr_load [2];
   logic deep;
   logic deep_d_r;
   logic deep_entry;
   logic [ssm_pkg::CNT_W-1:0] win_r;
   logic low_fast;
   logic high_sup_hit;
   logic high_mon_hit;
   logic affected;
   logic risky;
   logic [31:0] state_word;

   // Write channel: address and data are taken in either order.
   assign do_write = aw_have_r && w_have_r && !BVALID;
   assign wsel = reg_sel(aw_addr_r);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         aw_have_r <= 1'b0;
         AWREADY <= 1'b1;
         aw_addr_r <= '0;
      end
      else if (AWVALID && AWREADY)
      begin
         aw_have_r <= 1'b1;
         AWREADY <= 1'b0;
         aw_addr_r <= AWADDR;
      end
      else if (do_write)
      begin
         aw_have_r <= 1'b0;
         AWREADY <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         w_have_r <= 1'b0;
         WREADY <= 1'b1;
         w_data_r <= '0;
         w_lane0_r <= 1'b0;
      end
      else if (WVALID && WREADY)
      begin
         w_have_r <= 1'b1;
         WREADY <= 1'b0;
         w_data_r <= WDATA;
         w_lane0_r <= WSTRB[0];
      end
      else if (do_write)
      begin
         w_have_r <= 1'b0;
         WREADY <= 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         BVALID <= 1'b0;
         BRESP <= ssm_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         BVALID <= 1'b1;
         BRESP <= (wsel == SEL_NONE) ? ssm_pkg::RESP_SLVERR : ssm_pkg::RESP_OKAY;
      end
      else if (BREADY)
         BVALID <= 1'b0;
   end

   // Control registers. All fields sit in byte lane 0.
   assign low_wr = do_write && w_lane0_r && (wsel == SEL_LOW);
   assign high_wr = do_write && w_lane0_r && (wsel == SEL_HIGH);

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         low_ctl_r <= ssm_pkg::CTL_RST;
         high_ctl_r <= ssm_pkg::CTL_RST;
         mask_r <= ssm_pkg::MASK_RST;
      end
      else
      begin
         if (low_wr)
            low_ctl_r <= w_data_r[ssm_pkg::CTL_W-1:0];
         if (high_wr)
            high_ctl_r <= w_data_r[ssm_pkg::CTL_W-1:0];
         if (do_write && w_lane0_r && (wsel == SEL_MASK))
            mask_r <= w_data_r[ssm_pkg::ST_W-1:0];
      end
   end

   // Each control write restarts its side's settle delay. The delay length follows the
   // supervisor full performance bit being written, since that picks the comparator speed.
   assign tmr_start = {high_wr, low_wr};
   assign tmr_load[0] = w_data_r[ssm_pkg::BIT_SUP_FP] ?
      ssm_pkg::CNT_W'(ssm_pkg::SETTLE_FULL_CYC) : ssm_pkg::CNT_W'(SETTLE_NORM_CYC);
   assign tmr_load[1] = tmr_load[0];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_settle
         ssm_settle_timer u_tmr
         (
            .CLK(CLK),
            .ARST_N(ARST_N),
            .start(tmr_start[gi]),
            .load(tmr_load[gi]),
            .busy(tmr_busy[gi])
         );
      end
   endgenerate

   // Hazard check.
   assign low_fast = !low_ctl_r[ssm_pkg::BIT_SUP_EN] || low_ctl_r[ssm_pkg::BIT_SUP_FP]
      || !low_ctl_r[ssm_pkg::BIT_MON_EN] || low_ctl_r[ssm_pkg::BIT_MON_FP];
   assign high_sup_hit = high_ctl_r[ssm_pkg::BIT_SUP_EN] && !high_ctl_r[ssm_pkg::BIT_SUP_FP]
      && (!high_ctl_r[ssm_pkg::BIT_SUP_KEEP] || high_ctl_r[ssm_pkg::BIT_AUTO]);
   assign high_mon_hit = high_ctl_r[ssm_pkg::BIT_MON_EN] && !high_ctl_r[ssm_pkg::BIT_MON_FP]
      && high_ctl_r[ssm_pkg::BIT_AUTO];
   assign affected = low_fast && (high_sup_hit || high_mon_hit);
   // Deep entry is unsafe when affected or while either delay still runs.
   assign risky = affected || (|tmr_busy);

   // Mode tracking and the wake window after deep entry.
   assign deep = (PWR_MODE >= ssm_pkg::MODE_DEEP);
   assign deep_entry = deep && !deep_d_r;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         deep_d_r <= 1'b0;
         win_r <= '0;
      end
      else
      begin
         deep_d_r <= deep;
         if (deep_entry)
            win_r <= ssm_pkg::CNT_W'(ssm_pkg::WAKE_WIN_CYC);
         else if (win_r != '0)
            win_r <= win_r - 1'b1;
      end
   end

   // Lock-up is modelled, not prevented: only a reset or a soft clear leaves it.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         LOCKED_UP <= 1'b0;
      else if (SOFT_POWER_UP_CLEAR)
         LOCKED_UP <= 1'b0;
      else if ((win_r != '0) && WAKE_IRQ && risky)
         LOCKED_UP <= 1'b1;
   end

   // Registered unit states and check outputs.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         LOW_SUP_STATE <= ssm_pkg::UNIT_OFF;
         LOW_MON_STATE <= ssm_pkg::UNIT_OFF;
         HIGH_SUP_STATE <= ssm_pkg::UNIT_OFF;
         HIGH_MON_STATE <= ssm_pkg::UNIT_OFF;
         LOW_WAKE_FAST <= 1'b1;
         HAZARD_CHECK <= 1'b0;
      end
      else
      begin
         LOW_SUP_STATE <= unit_state(low_ctl_r[ssm_pkg::BIT_SUP_EN],
            low_ctl_r[ssm_pkg::BIT_SUP_KEEP], low_ctl_r[ssm_pkg::BIT_SUP_FP],
            low_ctl_r[ssm_pkg::BIT_AUTO], deep);
         LOW_MON_STATE <= unit_state(low_ctl_r[ssm_pkg::BIT_MON_EN], 1'b1,
            low_ctl_r[ssm_pkg::BIT_MON_FP], low_ctl_r[ssm_pkg::BIT_AUTO], deep);
         HIGH_SUP_STATE <= unit_state(high_ctl_r[ssm_pkg::BIT_SUP_EN],
            high_ctl_r[ssm_pkg::BIT_SUP_KEEP], high_ctl_r[ssm_pkg::BIT_SUP_FP],
            high_ctl_r[ssm_pkg::BIT_AUTO], deep);
         HIGH_MON_STATE <= unit_state(high_ctl_r[ssm_pkg::BIT_MON_EN], 1'b1,
            high_ctl_r[ssm_pkg::BIT_MON_FP], high_ctl_r[ssm_pkg::BIT_AUTO], deep);
         LOW_WAKE_FAST <= low_fast;
         HAZARD_CHECK <= affected;
      end
   end

   // Settle flags follow the timers one cycle later.
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         tmr_busy_d_r <= 2'h0;
         LOW_SETTLE_PENDING <= 1'b0;
         HIGH_SETTLE_PENDING <= 1'b0;
      end
      else
      begin
         tmr_busy_d_r <= tmr_busy;
         LOW_SETTLE_PENDING <= tmr_busy[0];
         HIGH_SETTLE_PENDING <= tmr_busy[1];
      end
   end

   // Sticky events; a read of the status register clears them, but a new event wins.
   assign events[ssm_pkg::ST_LOW_DONE] = tmr_busy_d_r[0] && !tmr_busy[0];
   assign events[ssm_pkg::ST_HIGH_DONE] = tmr_busy_d_r[1] && !tmr_busy[1];
   assign events[ssm_pkg::ST_LOCK] = (win_r != '0) && WAKE_IRQ && risky && !LOCKED_UP;
   assign events[ssm_pkg::ST_UNSAFE] = deep_entry && risky;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         status_r <= '0;
      else if (rd_take && (rsel == SEL_STATUS))
         status_r <= events;
      else
         status_r <= status_r | events;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         IRQ <= 1'b0;
      else
         IRQ <= |(status_r & mask_r);
   end

   // Read channel.
   assign rd_take = ARVALID && ARREADY;
   assign rsel = reg_sel(ARADDR);

   always_comb
   begin
      state_word = '0;
      state_word[ssm_pkg::LV_LOW_PEND] = LOW_SETTLE_PENDING;
      state_word[ssm_pkg::LV_HIGH_PEND] = HIGH_SETTLE_PENDING;
      state_word[ssm_pkg::LV_HAZARD] = HAZARD_CHECK;
      state_word[ssm_pkg::LV_LOW_FAST] = LOW_WAKE_FAST;
      state_word[ssm_pkg::LV_DEEP] = deep_d_r;
      state_word[ssm_pkg::LV_LOCKED] = LOCKED_UP;
      state_word[ssm_pkg::LV_LSUP +: 2] = LOW_SUP_STATE;
      state_word[ssm_pkg::LV_LMON +: 2] = LOW_MON_STATE;
      state_word[ssm_pkg::LV_HSUP +: 2] = HIGH_SUP_STATE;
      state_word[ssm_pkg::LV_HMON +: 2] = HIGH_MON_STATE;
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= ssm_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RRESP <= (rsel == SEL_NONE) ? ssm_pkg::RESP_SLVERR : ssm_pkg::RESP_OKAY;
         unique case (rsel)
            SEL_LOW: RDATA <= 32'(low_ctl_r);
            SEL_HIGH: RDATA <= 32'(high_ctl_r);
            SEL_STATUS: RDATA <= 32'(status_r);
            SEL_MASK: RDATA <= 32'(mask_r);
            SEL_STATE: RDATA <= state_word;
            default: RDATA <= '0;
         endcase
      end
      else if (RVALID && RREADY)
      begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   // Assertion helper: age of the last low-side control write and the speed it picked.
   // The length check reads both one cycle late, so a rewrite in the falling cycle is harmless.
   logic [ssm_pkg::CNT_W-1:0] low_age_r;
   logic low_age_fp_r;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         low_age_r <= '0;
         low_age_fp_r <= 1'b0;
      end
      else if (low_wr)
      begin
         low_age_r <= '0;
         low_age_fp_r <= w_data_r[ssm_pkg::BIT_SUP_FP];
      end
      else if (low_age_r != '1)
         low_age_r <= low_age_r + 1'b1;
   end

   sequence s_low_written_fp;
      low_wr && w_data_r[ssm_pkg::BIT_SUP_FP];
   endsequence

   sequence s_unsafe_irq;
      (win_r != '0) && WAKE_IRQ && risky && !SOFT_POWER_UP_CLEAR;
   endsequence

   a_low_fast_off: assert property (!low_ctl_r[ssm_pkg::BIT_MON_EN] |=> LOW_WAKE_FAST)
      else $error("Low monitor disabled but wake not fast.");
   a_low_slow: assert property (low_ctl_r[ssm_pkg::BIT_SUP_EN] && low_ctl_r[ssm_pkg::BIT_MON_EN]
      && !low_ctl_r[ssm_pkg::BIT_SUP_FP] && !low_ctl_r[ssm_pkg::BIT_MON_FP]
      |=> !LOW_WAKE_FAST)
      else $error("Low side enabled in normal mode but wake fast.");
   a_hazard_sup: assert property (low_fast && high_ctl_r[ssm_pkg::BIT_SUP_EN]
      && !high_ctl_r[ssm_pkg::BIT_SUP_FP] && !high_ctl_r[ssm_pkg::BIT_SUP_KEEP]
      |=> HAZARD_CHECK)
      else $error("Supervisor hazard not reported.");
   a_hazard_mon: assert property (low_fast && high_mon_hit |=> HAZARD_CHECK)
      else $error("Monitor hazard not reported.");
   a_hazard_none: assert property (!high_ctl_r[ssm_pkg::BIT_SUP_EN]
      && !high_ctl_r[ssm_pkg::BIT_MON_EN] |=> !HAZARD_CHECK)
      else $error("Hazard reported with high side disabled.");
   a_deep_auto_off: assert property (deep && high_ctl_r[ssm_pkg::BIT_AUTO]
      && !high_ctl_r[ssm_pkg::BIT_MON_FP] |=> HIGH_MON_STATE == ssm_pkg::UNIT_OFF)
      else $error("Automatic normal monitor not off in deep mode.");
   a_deep_auto_norm: assert property (deep && low_ctl_r[ssm_pkg::BIT_AUTO]
      && low_ctl_r[ssm_pkg::BIT_SUP_EN] && low_ctl_r[ssm_pkg::BIT_SUP_KEEP]
      && low_ctl_r[ssm_pkg::BIT_SUP_FP] |=> LOW_SUP_STATE == ssm_pkg::UNIT_NORMAL)
      else $error("Automatic kept full unit not normal in deep mode.");
   a_active_full: assert property (!deep && high_ctl_r[ssm_pkg::BIT_SUP_EN]
      && high_ctl_r[ssm_pkg::BIT_SUP_FP] |=> HIGH_SUP_STATE == ssm_pkg::UNIT_FULL)
      else $error("Full performance unit not full in active mode.");
   a_settle_fast: assert property (s_low_written_fp |=> ##1 LOW_SETTLE_PENDING [*8])
      else $error("Settle flag did not rise after a fast control write.");
   a_settle_len: assert property ($fell(LOW_SETTLE_PENDING) |-> $past(low_age_r)
      == ($past(low_age_fp_r) ? ssm_pkg::CNT_W'(ssm_pkg::SETTLE_FULL_CYC)
      : ssm_pkg::CNT_W'(SETTLE_NORM_CYC)))
      else $error("Low settle flag length does not match the written speed.");
   a_lock_set: assert property (s_unsafe_irq |=> LOCKED_UP
      ##1 (LOCKED_UP || $past(SOFT_POWER_UP_CLEAR)))
      else $error("Wake interrupt in hazard window did not lock up.");
   a_lock_hold: assert property (LOCKED_UP && !SOFT_POWER_UP_CLEAR |=> LOCKED_UP)
      else $error("Lock-up released without soft clear.");
endmodule // ssm_top

/* File: src/ssm_pkg.sv */
// Shared constants for the supply supervisor low-power mode controller.
// Assumes a 100 MHz system clock and an AXI4-Lite register port.
package ssm_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFF_LOW_CTL = 8'h00;
   localparam logic [7:0] OFF_HIGH_CTL = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0C;
   localparam logic [7:0] OFF_STATE = 8'h10;
   localparam int ADDR_W = 8;
   // Control register layout, shared by the low side and the high side.
   localparam int CTL_W = 6;
   localparam int BIT_SUP_EN = 0;
   localparam int BIT_SUP_KEEP = 1;
   localparam int BIT_SUP_FP = 2;
   localparam int BIT_MON_EN = 3;
   localparam int BIT_MON_FP = 4;
   localparam int BIT_AUTO = 5;
   localparam logic [CTL_W-1:0] CTL_RST = 6'h00;
   // Sticky status and mask layout.
   localparam int ST_W = 4;
   localparam int ST_LOW_DONE = 0;
   localparam int ST_HIGH_DONE = 1;
   localparam int ST_LOCK = 2;
   localparam int ST_UNSAFE = 3;
   localparam logic [ST_W-1:0] MASK_RST = 4'h0;
   // Live state register layout.
   localparam int LV_LOW_PEND = 0;
   localparam int LV_HIGH_PEND = 1;
   localparam int LV_HAZARD = 2;
   localparam int LV_LOW_FAST = 3;
   localparam int LV_DEEP = 4;
   localparam int LV_LOCKED = 5;
   localparam int LV_LSUP = 8;
   localparam int LV_LMON = 10;
   localparam int LV_HSUP = 12;
   localparam int LV_HMON = 14;
   // Power mode codes on the mode input.
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_LIGHT = 2'h1;
   localparam logic [1:0] MODE_DEEP = 2'h2;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing.
   localparam int CLK_PERIOD_NS = 10;
   localparam int SETTLE_FULL_NS = 2000;
   localparam int SETTLE_NORM_NS = 150000;
   localparam int WAKE_WIN_NS = 1000;
   localparam int SETTLE_FULL_CYC = (SETTLE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_NORM_CYC = (SETTLE_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_WIN_CYC = WAKE_WIN_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // Operating state of one supervisor or monitor.
   typedef enum logic [1:0] {UNIT_OFF, UNIT_NORMAL, UNIT_FULL} ssm_unit_e;
endpackage

/* File: src/ssm_settle_timer.sv */
// Down-counter that holds a busy flag for a loaded number of cycles.
// Assumes start is a one-cycle pulse; a new start reloads the count.
`timescale 1ns/10ps
module ssm_settle_timer
(
   // Clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // Control
   input wire logic start,
   input wire logic [ssm_pkg::CNT_W-1:0] load,
   // Status
   output logic busy
);
   logic [ssm_pkg::CNT_W-1:0] cnt_r;

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cnt_r <= '0;
         busy <= 1'b0;
      end
      else if (start)
      begin
         cnt_r <= load;
         busy <= (load != '0);
      end
      else if (cnt_r != '0)
      begin
         cnt_r <= cnt_r - 1'b1;
         busy <= (cnt_r != 16'h0001);
      end
   end
endmodule // ssm_settle_timer

/* File: tb/ssm_top_test.sv */
// Self-checking bench for the supply supervisor mode controller.
// Assumes ssm_pkg is compiled first; drives the AXI4-Lite port directly.
`timescale 1ns/10ps
module ssm_top_test;
   logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, wake, spuc;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0] bresp, rresp, pmode, lss, lms, hss, hms;
   logic awready, wready, bvalid, arready, rvalid, lfast, hazard, lpend, hpend, locked, irq;
   int failures = 0;
   int check_count = 0;
   ssm_top #(.SETTLE_NORM_CYC(300)) u_dut
   (
      .CLK(clk), .ARST_N(arst_n),
      .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
      .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
      .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
      .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0),
      .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
      .PWR_MODE(pmode), .WAKE_IRQ(wake), .SOFT_POWER_UP_CLEAR(spuc),
      .LOW_SUP_STATE(lss), .LOW_MON_STATE(lms), .HIGH_SUP_STATE(hss), .HIGH_MON_STATE(hms),
      .LOW_WAKE_FAST(lfast), .HAZARD_CHECK(hazard), .LOW_SETTLE_PENDING(lpend),
      .HIGH_SETTLE_PENDING(hpend), .LOCKED_UP(locked), .IRQ(irq)
   );
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tmo;
      failures++;
      $display("CHECK FAILED wait expected done seen timeout");
      print_verdict();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid && n < 40);
      if (n >= 40) tmo();
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid && n < 40);
      if (n >= 40) tmo();
      d = rdata;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   // Deep-mode entry is only safe once both settle flags are low.
   task automatic settle;
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      while ((lpend || hpend) && n < 1000)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 1000) tmo();
   endtask
   function automatic logic [1:0] ust(logic en, logic keep, logic fp, logic au, logic dp);
      if (!en) return 2'h0;
      if (!dp) return fp ? 2'h2 : 2'h1;
      if (au) return (keep && fp) ? 2'h1 : 2'h0;
      return keep ? (fp ? 2'h2 : 2'h1) : 2'h0;
   endfunction
   // Control layout: 0 sup en, 1 sup keep, 2 sup fp, 3 mon en, 4 mon fp, 5 auto.
   function automatic logic lf(logic [5:0] l);
      return !l[0] || l[2] || !l[3] || l[4];
   endfunction
   function automatic logic hz(logic [5:0] l, logic [5:0] h);
      return lf(l) && ((h[0] && !h[2] && (!h[1] || h[5])) || (h[3] && !h[4] && h[5]));
   endfunction
   task automatic t_reset;
      chk("reset outputs", 32'h8, {20'h0, lss, lms, hss, hms, lfast, hazard, irq, locked});
      rd(8'h00, 2'h0);
      chk("low ctl reset", 32'h0, d);
   endtask
   task automatic t_table;
      logic [5:0] lo [4] = '{6'h00, 6'h09, 6'h2F, 6'h0B};
      logic [5:0] hi [6] = '{6'h01, 6'h03, 6'h23, 6'h07, 6'h28, 6'h08};
      logic dp;
      foreach (lo[i]) foreach (hi[j])
      begin
         wr(8'h00, {26'h0, lo[i]}, 2'h0);
         wr(8'h04, {26'h0, hi[j]}, 2'h0);
         for (int m = 0; m < 3; m++)
         begin
            pmode <= m[1:0];
            dp = (m == 2);
            repeat (3) @(posedge clk);
            chk("low sup", ust(lo[i][0], lo[i][1], lo[i][2], lo[i][5], dp), lss);
            chk("low mon", ust(lo[i][3], 1'h1, lo[i][4], lo[i][5], dp), lms);
            chk("high sup", ust(hi[j][0], hi[j][1], hi[j][2], hi[j][5], dp), hss);
            chk("high mon", ust(hi[j][3], 1'h1, hi[j][4], hi[j][5], dp), hms);
            chk("low fast", {31'h0, lf(lo[i])}, {31'h0, lfast});
            chk("hazard", {31'h0, hz(lo[i], hi[j])}, {31'h0, hazard});
         end
         pmode <= 2'h0;
      end
   endtask
   task automatic t_settle_irq;
      int n;
      settle();
      rd(8'h08, 2'h0);
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h0C, k ? 32'h0 : 32'h1, 2'h0);
         wr(8'h00, k ? 32'h1 : 32'h5, 2'h0);
         repeat (3) @(posedge clk);
         chk("pending", 32'h1, {31'h0, lpend});
         n = 0;
         while (lpend && n < 400)
         begin
            @(posedge clk);
            n++;
         end
         chk("settle len", 32'h1, {31'h0, n > (k ? 290 : 190) && n <= (k ? 300 : 200)});
         repeat (3) @(posedge clk);
         chk("irq", k ? 32'h0 : 32'h1, {31'h0, irq});
         rd(8'h08, 2'h0);
         chk("status", 32'h1, d);
         rd(8'h08, 2'h0);
         chk("status cleared", 32'h0, d);
         repeat (2) @(posedge clk);
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
   endtask
   task automatic t_lock;
      for (int k = 0; k < 2; k++)
      begin
         wr(8'h00, k ? 32'h9 : 32'h0, 2'h0);
         wr(8'h04, k ? 32'h3 : 32'h1, 2'h0);
         repeat (2) @(posedge clk);
         chk("high pending", 32'h1, {31'h0, hpend});
         settle();
         rd(8'h08, 2'h0);
         chk("settle done", 32'h3, d);
         pmode <= 2'h2;
         repeat (3) @(posedge clk);
         wake <= 1'h1;
         @(posedge clk);
         wake <= 1'h0;
         repeat (3) @(posedge clk);
         chk("locked", k ? 32'h0 : 32'h1, {31'h0, locked});
         rd(8'h08, 2'h0);
         chk("lock status", k ? 32'h0 : 32'hC, d);
         rd(8'h10, 2'h0);
         chk("live state", k ? 32'h1410 : 32'h3C, d);
         spuc <= 1'h1;
         @(posedge clk);
         spuc <= 1'h0;
         repeat (2) @(posedge clk);
         chk("unlocked", 32'h0, {31'h0, locked});
         pmode <= 2'h0;
         repeat (2) @(posedge clk);
      end
   endtask
   initial
   begin
      {arst_n, awvalid, wvalid, bready, arvalid, rready, wake, spuc} = 8'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      pmode = 2'h0;
      repeat (4) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      t_reset();
      t_table();
      t_settle_irq();
      t_lock();
      wr(8'h40, 32'h1, 2'h2);
      rd(8'h40, 2'h2);
      print_verdict();
   end
endmodule // ssm_top_test
